/* File: afe_diag_pkg.sv */
// Package for the front-end diagnostics and temperature setup register bank.
// Assumes a 32-bit APB slave; each register index maps to byte address 4*idx.
package afe_diag_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_TEMP_SOURCE_CONTROL = 8'h4c;
  localparam logic [7:0] IDX_FRONTEND_DIAG_FLAGS = 8'h5a;
  localparam logic [7:0] IDX_TEMP_AMP_INPUT_STYLE = 8'h60;
  localparam logic [7:0] IDX_DIAG_MASTER_SWITCH = 8'h61;
  localparam logic [7:0] IDX_FRONTEND_DIAG_ENABLES = 8'h62;
  localparam logic [7:0] IDX_FRONTEND_DIAG_SETUP = 8'h63;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h64;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EXC_LSB = 4;
  localparam int ROUTE_LSB = 0;
  localparam int PULLUP_DIS_BIT = 6;
  localparam int PULLDOWN_DIS_BIT = 5;
  localparam int THR_LSB = 2;
  localparam int PD_LSB = 0;
  localparam int FLAG_RSVD_BIT = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] EXC_RESET = 3'h4;
  localparam logic [3:0] ROUTE_RESET = 4'h0;
  localparam logic [3:0] ROUTE_EXTERNAL = 4'h0;
  localparam logic [3:0] ROUTE_INTERNAL = 4'h3;
  localparam logic DIFF_RESET = 1'b0;
  localparam logic DIAG_ON_RESET = 1'b0;
  localparam logic [7:0] ENABLES_RESET = 8'h33;
  localparam logic [2:0] THR_RESET = 3'h1;
  localparam logic [1:0] PD_RESET = 2'h3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_VALID = 8'hf7;

  // Excitation codes (microamps); codes with bit 2 set mean off.
  localparam logic [9:0] EXC_UA_0 = 10'h019;
  localparam logic [9:0] EXC_UA_1 = 10'h032;
  localparam logic [9:0] EXC_UA_2 = 10'h064;
  localparam logic [9:0] EXC_UA_3 = 10'h1f4;

  // One flag per comparator; bit 3 has no comparator behind it.
  typedef struct packed {
    logic temp_amp_out_under;
    logic temp_amp_out_over;
    logic press_amp_out_under;
    logic press_amp_out_over;
    logic reserved;
    logic temp_amp_in_over;
    logic press_amp_in_under;
    logic press_amp_in_over;
  } diag_flags_t;

  // Input fault limits in tenths of a percent of bridge supply voltage.
  typedef struct packed {
    logic [9:0] under_permille;
    logic [9:0] over_permille;
    logic [1:0] bridge_class;
  } fault_limits_t;

endpackage

/* File: afe_diag_temp_config_regs.sv */
// Register bank for the temperature channel setup and the analog diagnostics.
// Assumes an APB master on pclk and comparator reports synchronous to pclk.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns

// How it works
// - Excitation code 0-3 gives 25/50/100/500 uA; top bit set is off.
// - Route code 0 selects external pair, code 3 internal sensor.
// - Style bit: clear single-ended, set differential; resets clear.
// - Master diagnostics bit gates all diagnostics; resets disabled.
// - Enable bits 7 and 6 cover temperature amp outputs; reset off.
// - Enable bits 5 and 4 cover pressure amp outputs; reset on.
// - Enable bit 2 covers temperature inputs; bit 3 reserved zero.
// - Enable bits 1 and 0 cover pressure amp inputs; reset on.
// - Setup bit 6 set disables temperature pull-ups; resets clear.
// - Setup bit 5 set disables pressure pull-downs; resets clear.
// - Threshold codes 0-2 give 2.5 V bridge limits; code 1 at reset.
// - Threshold codes 3-5 give 2 V bridge limits.
// - Threshold codes 6-7 give 1.25 V bridge limits.
// - Pull-down code 0-3 selects 4/2/3/1 megohm; resets to 3.
// - Writing one clears a status flag; zero leaves it alone.
// - A flag at one reports its fault occurred; zero means none.
// - Single-ended temperature amp raises output undervoltage while master and enable bit 7 are on.
module afe_diag_temp_config_regs
  import afe_diag_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator reports from the analog front end
  input wire diag_flags_t fault_seen,
  // Temperature channel controls
  output logic [2:0] temp_excitation_current_sel,
  output logic [9:0] excitation_ua,
  output logic excitation_on,
  output logic [3:0] temp_input_route_sel,
  output logic route_external_pair,
  output logic route_internal_sensor,
  output logic temp_amp_differential,
  // Diagnostic controls
  output logic diagnostics_on,
  output logic [7:0] detector_active,
  output logic temp_pullup_disable,
  output logic press_pulldown_disable,
  output logic [2:0] input_fault_threshold_sel,
  output fault_limits_t fault_limits,
  output logic [1:0] pulldown_value_sel,
  output logic [2:0] pulldown_megohm,
  // Interrupt
  output logic irq
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [2:0] exc_q, exc_d;
  logic [3:0] route_q, route_d;
  logic diff_q, diff_d;
  logic diag_on_q, diag_on_d;
  logic [7:0] enables_q, enables_d;
  logic pullup_dis_q, pullup_dis_d;
  logic pulldown_dis_q, pulldown_dis_d;
  logic [2:0] thr_q, thr_d;
  logic [1:0] pd_q, pd_d;
  diag_flags_t flags_q, flags_d;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, prdata_d;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle, which gives
  // the read mux a full cycle and keeps prdata straight from a flop.
  wire access_w = psel & penable;
  wire first_acc = access_w & ~pready_q;
  wire commit = access_w & pready_q;
  wire wr_commit = commit & pwrite;
  wire [ADDR_W-3:0] word_idx = paddr[ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire hit_temp = aligned &&
    (word_idx == (ADDR_W-2)'(IDX_TEMP_SOURCE_CONTROL));
  wire hit_flags = aligned &&
    (word_idx == (ADDR_W-2)'(IDX_FRONTEND_DIAG_FLAGS));
  wire hit_style = aligned &&
    (word_idx == (ADDR_W-2)'(IDX_TEMP_AMP_INPUT_STYLE));
  wire hit_master = aligned &&
    (word_idx == (ADDR_W-2)'(IDX_DIAG_MASTER_SWITCH));
  wire hit_enab = aligned &&
    (word_idx == (ADDR_W-2)'(IDX_FRONTEND_DIAG_ENABLES));
  wire hit_setup = aligned &&
    (word_idx == (ADDR_W-2)'(IDX_FRONTEND_DIAG_SETUP));
  wire hit_mask = aligned && (word_idx == (ADDR_W-2)'(IDX_IRQ_MASK));
  wire hit_any = hit_temp | hit_flags | hit_style | hit_master | hit_enab |
                 hit_setup | hit_mask;
  wire [7:0] wbyte = pwdata[7:0];

  // --------------------------------------------------------------------
  // Control register next values
  // --------------------------------------------------------------------
  // Reserved bits are not stored; they read back as zero.
  assign exc_d = (wr_commit && hit_temp) ? wbyte[EXC_LSB+:3] : exc_q;
  assign route_d = (wr_commit && hit_temp) ? wbyte[ROUTE_LSB+:4] : route_q;
  assign diff_d = (wr_commit && hit_style) ? wbyte[0] : diff_q;
  assign diag_on_d = (wr_commit && hit_master) ? wbyte[0] : diag_on_q;
  // The reserved enable bit is forced to zero whatever is written.
  assign enables_d = (wr_commit && hit_enab) ? (wbyte & FLAG_VALID)
                                             : enables_q;
  assign pullup_dis_d = (wr_commit && hit_setup) ? wbyte[PULLUP_DIS_BIT]
                                                 : pullup_dis_q;
  assign pulldown_dis_d = (wr_commit && hit_setup) ? wbyte[PULLDOWN_DIS_BIT]
                                                   : pulldown_dis_q;
  assign thr_d = (wr_commit && hit_setup) ? wbyte[THR_LSB+:3] : thr_q;
  assign pd_d = (wr_commit && hit_setup) ? wbyte[PD_LSB+:2] : pd_q;
  assign irq_mask_d = (wr_commit && hit_mask) ? (wbyte & FLAG_VALID)
                                              : irq_mask_q;

  // --------------------------------------------------------------------
  // Diagnostic flags
  // --------------------------------------------------------------------
  // A single-ended amplifier keeps one terminal at ground, so the output
  // undervoltage detector would trip anyway; it is reported as such.
  diag_flags_t cond_w;
  always_comb begin
    cond_w = fault_seen;
    cond_w.temp_amp_out_under = fault_seen.temp_amp_out_under |
                                ~diff_q;
    cond_w.reserved = 1'b0;
  end
  wire [7:0] set_w = {8{diag_on_q}} & enables_q & cond_w &
                     FLAG_VALID;
  wire [7:0] clr_w = (wr_commit && hit_flags) ? wbyte : 8'h00;
  // Set beats clear so a fault landing on the clearing write is kept.
  assign flags_d = ((flags_q & ~clr_w) | set_w) &
                   FLAG_VALID;

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_temp) begin
      prdata_d[EXC_LSB+:3] = exc_q;
      prdata_d[ROUTE_LSB+:4] = route_q;
    end else if (hit_flags) begin
      prdata_d[7:0] = flags_q;
    end else if (hit_style) begin
      prdata_d[0] = diff_q;
    end else if (hit_master) begin
      prdata_d[0] = diag_on_q;
    end else if (hit_enab) begin
      prdata_d[7:0] = enables_q;
    end else if (hit_setup) begin
      prdata_d[PULLUP_DIS_BIT] = pullup_dis_q;
      prdata_d[PULLDOWN_DIS_BIT] = pulldown_dis_q;
      prdata_d[THR_LSB+:3] = thr_q;
      prdata_d[PD_LSB+:2] = pd_q;
    end else if (hit_mask) begin
      prdata_d[7:0] = irq_mask_q;
    end
  end

  // --------------------------------------------------------------------
  // Decoded analog settings (from next values so they track the registers)
  // --------------------------------------------------------------------
  logic [9:0] exc_ua_d;
  fault_limits_t limits_d;
  logic [2:0] pd_mohm_d;
  always_comb begin
    case (exc_d)
      3'h0: exc_ua_d = EXC_UA_0;
      3'h1: exc_ua_d = EXC_UA_1;
      3'h2: exc_ua_d = EXC_UA_2;
      3'h3: exc_ua_d = EXC_UA_3;
      default: exc_ua_d = 10'h000;
    endcase
    case (thr_d)
      3'h0: limits_d = '{10'd75, 10'd725, 2'h0};
      3'h1: limits_d = '{10'd100, 10'd700, 2'h0};
      3'h2: limits_d = '{10'd150, 10'd650, 2'h0};
      3'h3: limits_d = '{10'd100, 10'd900, 2'h1};
      3'h4: limits_d = '{10'd125, 10'd875, 2'h1};
      3'h5: limits_d = '{10'd175, 10'd825, 2'h1};
      3'h6: limits_d = '{10'd175, 10'd1000, 2'h2};
      default: limits_d = '{10'd225, 10'd950, 2'h2};
    endcase
    case (pd_d)
      2'h0: pd_mohm_d = 3'h4;
      2'h1: pd_mohm_d = 3'h2;
      2'h2: pd_mohm_d = 3'h3;
      default: pd_mohm_d = 3'h1;
    endcase
  end

  // --------------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_q <= EXC_RESET;
      route_q <= ROUTE_RESET;
      diff_q <= DIFF_RESET;
      diag_on_q <= DIAG_ON_RESET;
      enables_q <= ENABLES_RESET;
      pullup_dis_q <= 1'b0;
      pulldown_dis_q <= 1'b0;
      thr_q <= THR_RESET;
      pd_q <= PD_RESET;
      flags_q <= FLAGS_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end else begin
      exc_q <= exc_d;
      route_q <= route_d;
      diff_q <= diff_d;
      diag_on_q <= diag_on_d;
      enables_q <= enables_d;
      pullup_dis_q <= pullup_dis_d;
      pulldown_dis_q <= pulldown_dis_d;
      thr_q <= thr_d;
      pd_q <= pd_d;
      flags_q <= flags_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // Bus answer flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= first_acc;
      pslverr_q <= first_acc & ~hit_any;
      prdata_q <= (first_acc && !pwrite) ? prdata_d : 32'h0000_0000;
    end
  end

  // Output flops for the analog controls and the interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_excitation_current_sel <= EXC_RESET;
      excitation_ua <= 10'h000;
      excitation_on <= 1'b0;
      temp_input_route_sel <= ROUTE_RESET;
      route_external_pair <= 1'b0;
      route_internal_sensor <= 1'b0;
      temp_amp_differential <= DIFF_RESET;
      diagnostics_on <= DIAG_ON_RESET;
      detector_active <= 8'h00;
      temp_pullup_disable <= 1'b0;
      press_pulldown_disable <= 1'b0;
      input_fault_threshold_sel <= THR_RESET;
      fault_limits <= '0;
      pulldown_value_sel <= PD_RESET;
      pulldown_megohm <= 3'h0;
      irq <= 1'b0;
    end else begin
      temp_excitation_current_sel <= exc_d;
      excitation_ua <= exc_ua_d;
      excitation_on <= ~exc_d[2];
      temp_input_route_sel <= route_d;
      route_external_pair <= (route_d == ROUTE_EXTERNAL);
      route_internal_sensor <= (route_d == ROUTE_INTERNAL);
      temp_amp_differential <= diff_d;
      diagnostics_on <= diag_on_d;
      detector_active <= {8{diag_on_d}} & enables_d;
      temp_pullup_disable <= pullup_dis_d;
      press_pulldown_disable <= pulldown_dis_d;
      input_fault_threshold_sel <= thr_d;
      fault_limits <= limits_d;
      pulldown_value_sel <= pd_d;
      pulldown_megohm <= pd_mohm_d;
      irq <= |(flags_d & irq_mask_d);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  exc_off_a:
    assert property (temp_excitation_current_sel[2] |->
                     (!excitation_on && excitation_ua == 10'h000))
    else $error("Excitation reported on with an off code.");

  route_int_a:
    assert property (route_internal_sensor == (temp_input_route_sel == 4'h3))
    else $error("Internal sensor routing does not match the route code.");

  style_wr_a:
    assert property (wr_commit && hit_style |=> diff_q == $past(pwdata[0]))
    else $error("Amplifier style did not take the written value.");

  master_gate_a:
    assert property (!diag_on_q |=> flags_q == $past(flags_q & ~clr_w))
    else $error("A flag was set while diagnostics were off.");

  mask_gate_a:
    assert property (diag_on_q && !enables_q[7] && !flags_q[7]
                     && !(wr_commit && hit_enab) |=> !flags_q[7])
    else $error("Disabled output undervoltage flag was set.");

  rsvd_enable_a:
    assert property (!enables_q[3])
    else $error("Reserved enable bit is set.");

  thr_limits_a:
    assert property (input_fault_threshold_sel == 3'h4 |->
                     fault_limits.under_permille == 10'd125 &&
                     fault_limits.over_permille == 10'd875)
    else $error("Threshold code 4 limits are wrong.");

  pd_value_a:
    assert property (pulldown_value_sel == 2'h2 |-> pulldown_megohm == 3'h3)
    else $error("Pull-down code 2 does not give three megohm.");

  w1c_a:
    assert property (wr_commit && hit_flags && !wbyte[0] && flags_q[0]
                     |=> flags_q[0])
    else $error("Writing zero cleared a status flag.");

  sticky_set_a:
    assert property (diag_on_q && enables_q[0] && fault_seen[0]
                     |=> flags_q[0] ##1 flags_q[0] || $past(clr_w[0]))
    else $error("Reported fault did not set its sticky flag.");

  single_end_a:
    assert property (diag_on_q && enables_q[7] && !diff_q |=> flags_q[7])
    else $error("Single-ended mode did not flag output undervoltage.");

  rsvd_flag_a:
    assert property (!flags_q[FLAG_RSVD_BIT])
    else $error("Reserved status bit reads one.");

  apb_wait_a:
    assert property (psel && penable && !pready |=> pready)
    else $error("APB answer did not come one cycle into the access.");

  diag_out_a:
    assert property (diagnostics_on == diag_on_q &&
                     detector_active == ({8{diag_on_q}} & enables_q))
    else $error("Diagnostic outputs do not follow the master and enables.");

  set_wins_a:
    assert property (diag_on_q && enables_q[2] && fault_seen[2] &&
                     wr_commit && hit_flags |=> flags_q[2])
    else $error("A clearing write dropped a fault seen in the same cycle.");

  pull_cfg_a:
    assert property (wr_commit && hit_setup |=>
                     temp_pullup_disable == $past(pwdata[PULLUP_DIS_BIT]) &&
                     press_pulldown_disable == $past(pwdata[PULLDOWN_DIS_BIT]))
    else $error("Pull resistor disables did not take the written bits.");

  thr_class_a:
    assert property (fault_limits.bridge_class ==
                     ((input_fault_threshold_sel < 3'h3) ? 2'h0 :
                      (input_fault_threshold_sel < 3'h6) ? 2'h1 : 2'h2))
    else $error("Bridge supply class does not match the threshold code.");

  // Both sides are flops loaded at the same edge, so they must agree always.
  irq_level_a:
    assert property (irq == |(flags_q & irq_mask_q))
    else $error("Interrupt does not follow masked status.");

endmodule

/* File: afe_diag_temp_config_regs_tb.sv */
// Self-checking bench for the temperature and diagnostics register bank.
// Assumes the bank answers APB itself; the bench waits for pready.
`timescale 1ns/1ns
module afe_diag_temp_config_regs_tb;
  import afe_diag_pkg::*;

  // ------------------------------------------------------------------
  // Signals and address map
  // ------------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  diag_flags_t fault_seen;
  logic [2:0] cur_sel, thr_sel, megohm;
  logic [9:0] exc_ua;
  logic [3:0] route_sel;
  logic exc_on, route_ext, route_int, diff, diag_on, pu_dis, pd_dis;
  logic [7:0] det_active;
  logic [1:0] pd_sel;
  fault_limits_t limits;
  int failures = 0;
  int n_compared = 0;
  localparam logic [11:0] A_TC = {2'b00, IDX_TEMP_SOURCE_CONTROL, 2'b00};
  localparam logic [11:0] A_FL = {2'b00, IDX_FRONTEND_DIAG_FLAGS, 2'b00};
  localparam logic [11:0] A_ST = {2'b00, IDX_TEMP_AMP_INPUT_STYLE, 2'b00};
  localparam logic [11:0] A_MS = {2'b00, IDX_DIAG_MASTER_SWITCH, 2'b00};
  localparam logic [11:0] A_EN = {2'b00, IDX_FRONTEND_DIAG_ENABLES, 2'b00};
  localparam logic [11:0] A_SU = {2'b00, IDX_FRONTEND_DIAG_SETUP, 2'b00};
  localparam logic [11:0] A_IM = {2'b00, IDX_IRQ_MASK, 2'b00};

  afe_diag_temp_config_regs #(.ADDR_W(12)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_seen(fault_seen),
    .temp_excitation_current_sel(cur_sel), .excitation_ua(exc_ua),
    .excitation_on(exc_on), .temp_input_route_sel(route_sel),
    .route_external_pair(route_ext), .route_internal_sensor(route_int),
    .temp_amp_differential(diff), .diagnostics_on(diag_on),
    .detector_active(det_active), .temp_pullup_disable(pu_dis),
    .press_pulldown_disable(pd_dis), .input_fault_threshold_sel(thr_sel),
    .fault_limits(limits), .pulldown_value_sel(pd_sel),
    .pulldown_megohm(megohm), .irq(irq));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      failures++;
      $display("wrong value at %0t: bus never answered", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
    chk({31'h0, e}, 32'h0, "write error flag");
    @(negedge pclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] x,
                     input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, {24'h0, x}, m);
    chk({31'h0, e}, 32'h0, "read error flag");
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge pclk);
    fault_seen <= v;
    @(posedge pclk);
    fault_seen <= 8'h00;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rdc(A_TC, 8'h40, "source control");
    rdc(A_FL, 8'h00, "flags");
    rdc(A_ST, 8'h00, "style");
    rdc(A_MS, 8'h00, "master");
    rdc(A_EN, 8'h33, "enables");
    rdc(A_SU, 8'h07, "setup");
    rdc(A_IM, 8'h00, "irq mask");
    chk({31'h0, exc_on}, 32'h0, "source off");
    chk({31'h0, route_ext}, 32'h1, "external");
    chk({29'h0, megohm}, 32'h1, "megohm");
    chk({10'h0, limits}, {10'h0, 10'd100, 10'd700, 2'd0}, "lim");
    chk({19'h0, cur_sel, route_sel, thr_sel, pd_sel, diag_on},
        {19'h0, 3'h4, 4'h0, 3'h1, 2'h3, 1'b0}, "copies");
  endtask

  // Every excitation code, with the reserved top bit written as one.
  task automatic t_excitation();
    int ua[4] = '{25, 50, 100, 500};
    for (int i = 0; i < 8; i++) begin
      wr(A_TC, {1'b1, 3'(i), 4'h3});
      rdc(A_TC, {1'b0, 3'(i), 4'h3}, "source control");
      chk({22'h0, exc_ua}, (i > 3) ? 32'h0 : ua[i % 4], "uA");
      chk({31'h0, exc_on}, {31'h0, i < 4}, "source on");
      chk({31'h0, route_int}, 32'h1, "internal");
      chk({25'h0, cur_sel, route_sel}, {25'h0, 3'(i), 4'h3},
          "selects");
    end
    wr(A_TC, 8'h40);
    chk({31'h0, route_ext}, 32'h1, "external");
    chk({31'h0, route_int}, 32'h0, "internal");
  endtask

  // Every threshold and pull-down code, with both disable bits exercised.
  task automatic t_setup();
    int und[8] = '{75, 100, 150, 100, 125, 175, 175, 225};
    int ovr[8] = '{725, 700, 650, 900, 875, 825, 1000, 950};
    int cls[8] = '{0, 0, 0, 1, 1, 1, 2, 2};
    int meg[4] = '{4, 2, 3, 1};
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, i[0], i[1], 3'(i), 2'(i)};
      wr(A_SU, v);
      rdc(A_SU, v, "setup");
      chk({10'h0, limits}, {10'h0, 10'(und[i]), 10'(ovr[i]), 2'(cls[i])},
          "limits");
      chk({29'h0, megohm}, meg[i % 4], "megohm");
      chk({27'h0, thr_sel, pd_sel}, {27'h0, 3'(i), 2'(i)}, "sel");
      chk({30'h0, pu_dis, pd_dis}, {30'h0, v[6], v[5]}, "pulls");
    end
  endtask

  // Gating, stickiness, write-one-clear and the forced single-ended flag.
  task automatic t_flags();
    pulse(8'hff);
    rdc(A_FL, 8'h00, "flags master off");
    wr(A_MS, 8'h01);
    chk({24'h0, det_active}, 32'h33, "active");
    chk({31'h0, diag_on}, 32'h1, "master out");
    pulse(8'hff);
    rdc(A_FL, 8'h33, "flags default enables");
    wr(A_FL, 8'h00);
    rdc(A_FL, 8'h33, "write zero");
    wr(A_FL, 8'h01);
    rdc(A_FL, 8'h32, "clear one");
    wr(A_FL, 8'hff);
    rdc(A_FL, 8'h00, "clear all");
    wr(A_EN, 8'hff);
    rdc(A_EN, 8'hf7, "enables");
    chk({24'h0, det_active}, 32'hf7, "active");
    rdc(A_FL, 8'h80, "single ended");
    pulse(8'h04);
    rdc(A_FL, 8'h84, "temp input");
    wr(A_ST, 8'h01);
    rdc(A_ST, 8'h01, "style");
    chk({31'h0, diff}, 32'h1, "differential");
    wr(A_FL, 8'hff);
    rdc(A_FL, 8'h00, "differential flags");
    // A fault that stands through a clearing write must survive it.
    @(posedge pclk);
    fault_seen <= 8'h04;
    wr(A_FL, 8'h04);
    @(posedge pclk);
    fault_seen <= 8'h00;
    rdc(A_FL, 8'h04, "set beats clear");
    wr(A_FL, 8'h04);
    rdc(A_FL, 8'h00, "clear after fault");
  endtask

  task automatic t_irq();
    wr(A_IM, 8'h04);
    chk({31'h0, irq}, 32'h0, "irq idle");
    pulse(8'h04);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(A_IM, 8'h00);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(A_IM, 8'h04);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(A_FL, 8'h04);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask

  // Unmapped and unaligned places answer with an error and change nothing.
  task automatic t_errors();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h200, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    apb(1'b1, A_TC + 12'h2, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unaligned error");
    rdc(A_TC, 8'h40, "source control kept");
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fault_seen = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_excitation();
    t_setup();
    t_flags();
    t_irq();
    t_errors();
    finish_test();
  end
endmodule
